// *** bench/socket_zoom_video_audio_ctl_bench.sv ***
// Self-checking testbench for the socket zoom video, oscillator, pull and audio logic.
`timescale 1ns/100ps
module socket_zoom_video_audio_ctl_bench;
  import szva_pkg::*;
  logic        core_clk, rst_n, reg_wr, reg_rd, reg_func, reg_cfg_space;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic        reg_rvalid, speaker_audio_out, pwm_audio_out, internal_clock_enable;
  logic        zoom_source_socket1;
  logic [1:0]  card_is_16bit, card_is_cardbus, card_io_mode, battery_voltage_2_pin;
  logic [1:0]  status_change_pin_pullup_en, status_change_pin_pulldown_en;
  logic [1:0]  addr_hi_release, socket_zoom_active, tone, zv, dg, osc, sup;
  logic [3:0]  card_kind;
  logic [7:0]  cc [2];
  int          err_total, num_checks;

  szva_ctl dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_func(reg_func), .reg_cfg_space(reg_cfg_space), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .card_is_16bit(card_is_16bit), .card_is_cardbus(card_is_cardbus),
    .card_io_mode(card_io_mode), .battery_voltage_2_pin(battery_voltage_2_pin),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .speaker_audio_out(speaker_audio_out),
    .pwm_audio_out(pwm_audio_out), .internal_clock_enable(internal_clock_enable),
    .status_change_pin_pullup_en(status_change_pin_pullup_en),
    .status_change_pin_pulldown_en(status_change_pin_pulldown_en),
    .addr_hi_release(addr_hi_release), .socket_zoom_active(socket_zoom_active),
    .zoom_source_socket1(zoom_source_socket1));

  szva_card_model card_u (.core_clk(core_clk), .card_kind(card_kind), .tone(tone),
    .card_is_16bit(card_is_16bit), .card_is_cardbus(card_is_cardbus),
    .card_io_mode(card_io_mode), .battery_voltage_2_pin(battery_voltage_2_pin));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  task automatic compare(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s at %0t: got %h expected %h", what, $time, got, exp);
    end
  endtask : compare

  // The shadow copies track what software wrote, so expectations never read the design.
  task automatic reg_write(input logic cfg, input logic f, input logic [7:0] a,
                           input logic [31:0] d);
    @(posedge core_clk);
    #1;
    reg_wr = 1'b1;
    reg_cfg_space = cfg;
    reg_func = f;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    if (cfg && a == SZVA_OFF_SYSTEM_CTL) osc[f] = d[27];
    if (cfg && a == SZVA_OFF_CARD_CTL) cc[f] = d[7:0] & SZVA_CARD_CTL_MASK;
    if (cfg && a == SZVA_OFF_DIAGNOSTIC) dg[f] = d[0];
    if (!cfg && a == SZVA_OFF_SOCKET_CTL) zv[f] = d[9];
    if (!cfg && a == SZVA_OFF_FORCE_EVENT && d[27]) sup[f] = 1'b1;
  endtask : reg_write

  task automatic reg_read(input logic cfg, input logic f, input logic [7:0] a,
                          input logic [31:0] exp);
    @(posedge core_clk);
    #1;
    reg_rd = 1'b1;
    reg_cfg_space = cfg;
    reg_func = f;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    rd_val = reg_rdata;
    compare({31'h0, reg_rvalid}, 32'h1, "rvalid");
    compare(reg_rdata, exp, "rdata");
  endtask : reg_read

  function automatic logic [1:0] eff();
    return {cc[1][6] | (zv[1] & ~dg[1]), cc[0][6] | (zv[0] & ~dg[0])};
  endfunction : eff

  function automatic logic [31:0] exp_ctl(input logic f);
    logic [1:0] en;
    en = eff();
    return {20'h0, |en, ~dg[f], zv[f], 9'h0};
  endfunction : exp_ctl

  function automatic logic [11:0] exp_pins();
    logic [1:0] en, au;
    logic       pwm;
    en = eff();
    au = battery_voltage_2_pin & {cc[1][1], cc[0][1]}
         & ((card_is_16bit & card_io_mode) | card_is_cardbus);
    pwm = cc[0][2] ? (battery_voltage_2_pin[0] & card_is_cardbus[0])
                   : (cc[1][2] & battery_voltage_2_pin[1] & card_is_cardbus[1]);
    return {^au, pwm, |osc, en, cc[1][6], cc[0][6], (&en) ? cc[0][5] : en[1],
            card_is_16bit, card_is_cardbus & ~card_is_16bit};
  endfunction : exp_pins

  task automatic chk_pins();
    repeat (2) @(posedge core_clk);
    #1;
    compare({20'h0, speaker_audio_out, pwm_audio_out, internal_clock_enable,
             socket_zoom_active, addr_hi_release, zoom_source_socket1,
             status_change_pin_pullup_en, status_change_pin_pulldown_en},
            {20'h0, exp_pins()}, "pins");
  endtask : chk_pins

  // Host software side: reads capability, support and activity before enabling.
  task automatic sw_enable(input logic f);
    logic [31:0] ctl;
    reg_read(1'b0, f, SZVA_OFF_SOCKET_CTL, exp_ctl(f));
    ctl = rd_val;
    reg_read(1'b0, f, SZVA_OFF_PRESENT_STATE, {4'h0, sup[f], 27'h0});
    if (ctl[10] === 1'b0) begin
      reg_write(1'b1, f, SZVA_OFF_CARD_CTL, {24'h0, cc[f] | 8'h40});
    end else if (rd_val[27] === 1'b1 && ctl[11] === 1'b0) begin
      reg_write(1'b0, f, SZVA_OFF_SOCKET_CTL, 32'h0000_0200);
    end
  endtask : sw_enable

  initial begin
    #100000;
    err_total++;
    results();
  end

  initial begin
    {reg_wr, reg_rd, reg_func, reg_cfg_space, rst_n} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    card_kind = 4'h0;
    tone = 2'h0;
    cc[0] = 8'h00;
    cc[1] = 8'h00;
    {zv, dg, osc, sup} = 8'h00;
    err_total = 0;
    num_checks = 0;
    repeat (3) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    chk_pins();
    reg_read(1'b0, 1'b1, SZVA_OFF_SOCKET_CTL, 32'h0000_0400);
    reg_read(1'b1, 1'b0, SZVA_OFF_SYSTEM_CTL, 32'h0);
    reg_read(1'b1, 1'b1, SZVA_OFF_CARD_CTL, 32'h0);
    reg_read(1'b1, 1'b0, SZVA_OFF_DIAGNOSTIC, 32'h0);
    $display("test reset done");
    reg_write(1'b0, 1'b0, SZVA_OFF_PRESENT_STATE, 32'h0800_0000);
    reg_read(1'b0, 1'b0, SZVA_OFF_PRESENT_STATE, 32'h0);
    reg_write(1'b0, 1'b0, SZVA_OFF_FORCE_EVENT, 32'h0800_0000);
    reg_write(1'b0, 1'b0, SZVA_OFF_FORCE_EVENT, 32'h0);
    reg_write(1'b0, 1'b0, 8'h14, 32'hFFFF_FFFF);
    reg_read(1'b0, 1'b0, 8'h14, 32'h0);
    reg_read(1'b0, 1'b1, SZVA_OFF_PRESENT_STATE, 32'h0);
    $display("test support flag done");
    sw_enable(1'b0);
    chk_pins();
    sw_enable(1'b1);
    reg_write(1'b0, 1'b1, SZVA_OFF_FORCE_EVENT, 32'h0800_0000);
    sw_enable(1'b1);
    reg_write(1'b0, 1'b0, SZVA_OFF_SOCKET_CTL, 32'h0);
    sw_enable(1'b1);
    chk_pins();
    reg_write(1'b1, 1'b1, SZVA_OFF_DIAGNOSTIC, 32'h1);
    chk_pins();
    sw_enable(1'b1);
    chk_pins();
    reg_write(1'b1, 1'b0, SZVA_OFF_CARD_CTL, 32'h0000_00FF);
    reg_read(1'b1, 1'b0, SZVA_OFF_CARD_CTL, 32'h0000_0066);
    chk_pins();
    reg_write(1'b1, 1'b0, SZVA_OFF_CARD_CTL, 32'h0000_0040);
    chk_pins();
    $display("test zoom enable done");
    reg_write(1'b1, 1'b1, SZVA_OFF_SYSTEM_CTL, 32'h0800_0000);
    reg_read(1'b1, 1'b1, SZVA_OFF_SYSTEM_CTL, 32'h0800_0000);
    chk_pins();
    reg_write(1'b1, 1'b1, SZVA_OFF_SYSTEM_CTL, 32'h0);
    chk_pins();
    $display("test oscillator done");
    // Every card pairing and tone against every speaker enable and routing choice.
    for (int m = 0; m < 16; m++) begin
      reg_write(1'b1, 1'b0, SZVA_OFF_CARD_CTL, {24'h0, 5'h08, m[1:0], 1'b0});
      reg_write(1'b1, 1'b1, SZVA_OFF_CARD_CTL, {24'h0, 5'h08, m[3:2], 1'b0});
      for (int k = 0; k < 64; k++) begin
        card_kind = k[3:0];
        tone = k[5:4];
        chk_pins();
      end
    end
    $display("test audio and pulls done");
    results();
  end
endmodule : socket_zoom_video_audio_ctl_bench

// *** bench/szva_card_model.sv ***
// Behavioural model of the two inserted PC Cards as seen at the socket pins.
`timescale 1ns/100ps
module szva_card_model (
  input  wire logic       core_clk,
  input  wire logic [3:0] card_kind,
  input  wire logic [1:0] tone,
  output logic [1:0]      card_is_16bit,
  output logic [1:0]      card_is_cardbus,
  output logic [1:0]      card_io_mode,
  output logic [1:0]      battery_voltage_2_pin
);
  // Kind per socket: 0 empty, 1 16-bit memory, 2 16-bit I/O, 3 CardBus.
  logic flip;

  initial flip = 1'b0;

  always @(posedge core_clk) begin
    flip <= ~flip;
  end

  for (genvar s = 0; s < 2; s++) begin : g_sock
    logic [1:0] k;
    assign k = card_kind[2*s +: 2];
    assign card_is_16bit[s]   = (k == 2'h1) || (k == 2'h2);
    assign card_io_mode[s]    = (k == 2'h2);
    assign card_is_cardbus[s] = (k == 2'h3);
    // Nothing drives the pin of an empty socket, so it shows a changing level.
    assign battery_voltage_2_pin[s] = (k == 2'h0) ? flip : tone[s];
  end
endmodule : szva_card_model

// *** verilog/szva_ctl.sv ***
// Top of the per-socket zoom video, internal clock, status pull and audio routing logic.
//
// Functional notes
// RULE1 - Present state bit 27 shows platform zoom support.
// RULE2 - Force event bit 27 write sets support flag.
// RULE3 - Control bit 11 set when either socket zooms.
// RULE4 - Control bit 10 reports standard zoom model.
// RULE5 - Control bit 9 enables zoom per socket.
// RULE6 - Diagnostic bit 0 disables standard zoom model.
// RULE7 - Legacy card control zoom enable still honoured.
// RULE8 - Software uses legacy path if bit 10 clear.
// RULE9 - Software may use standard bits if set.
// RULE10 - Software enables zoom only if supported, idle.
// RULE11 - Internal slow oscillator runs without external clocks.
// RULE12 - Oscillator off at reset, system bit 27 enables.
// RULE13 - Pullup for 16-bit card, pulldown for CardBus.
// RULE14 - 16-bit I/O card: voltage pin is speaker.
// RULE15 - Speaker output is XOR of both sockets.
// RULE16 - Speaker output active only while bit 1 set.
// RULE17 - Card control bit 2 routes PWM audio.
// RULE18 - Both routing PWM audio: socket 0 wins.
// RULE19 - Bit 6 releases address lines A25 to A4.
// RULE20 - Bit 5 picks zoom priority, default socket 0.
// RULE21 - Activity is OR of effective zoom enables.
// RULE22 - Effective enable is legacy OR standard enable.
`timescale 1ns/100ps
module szva_ctl
  import szva_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        reg_func,
  input  wire logic        reg_cfg_space,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic [1:0]  card_is_16bit,
  input  wire logic [1:0]  card_is_cardbus,
  input  wire logic [1:0]  card_io_mode,
  input  wire logic [1:0]  battery_voltage_2_pin,
  output logic [31:0]      reg_rdata,
  output logic             reg_rvalid,
  output logic             speaker_audio_out,
  output logic             pwm_audio_out,
  output logic             internal_clock_enable,
  output logic [1:0]       status_change_pin_pullup_en,
  output logic [1:0]       status_change_pin_pulldown_en,
  output logic [1:0]       addr_hi_release,
  output logic [1:0]       socket_zoom_active,
  output logic             zoom_source_socket1
);

  logic [1:0] wr_force_s;
  logic [1:0] wr_sock_ctl_s;
  logic [1:0] wr_sys_ctl_s;
  logic [1:0] wr_card_ctl_s;
  logic [1:0] wr_diag_s;
  logic [1:0] support_s;
  logic [1:0] std_en_s;
  logic [1:0] clk_en_s;
  logic [1:0] std_dis_s;
  logic [7:0] card_ctl_s [SZVA_SOCKETS];
  logic [1:0] legacy_en_s;
  logic [1:0] zoom_eff_s;
  logic [1:0] spk_en_s;
  logic [1:0] pwm_route_s;
  logic [1:0] card_speaker_in;
  logic [1:0] cardbus_audio_in;
  logic [1:0] audio_valid_s;
  logic       zoom_in_use_any_socket;
  logic [31:0] rdata_next;

  // Address decoding: socket space and configuration space share one port.
  always_comb begin
    wr_force_s    = 2'b00;
    wr_sock_ctl_s = 2'b00;
    wr_sys_ctl_s  = 2'b00;
    wr_card_ctl_s = 2'b00;
    wr_diag_s     = 2'b00;
    if (reg_wr && !reg_cfg_space && reg_addr == SZVA_OFF_FORCE_EVENT) begin
      wr_force_s[reg_func] = 1'b1;
    end else if (reg_wr && !reg_cfg_space && reg_addr == SZVA_OFF_SOCKET_CTL) begin
      wr_sock_ctl_s[reg_func] = 1'b1;
    end else if (reg_wr && reg_cfg_space && reg_addr == SZVA_OFF_SYSTEM_CTL) begin
      wr_sys_ctl_s[reg_func] = 1'b1;
    end else if (reg_wr && reg_cfg_space && reg_addr == SZVA_OFF_CARD_CTL) begin
      wr_card_ctl_s[reg_func] = 1'b1;
    end else if (reg_wr && reg_cfg_space && reg_addr == SZVA_OFF_DIAGNOSTIC) begin
      wr_diag_s[reg_func] = 1'b1;
    end
  end

  for (genvar s = 0; s < SZVA_SOCKETS; s++) begin : g_sock
    szva_socket_regs u_regs (
      .core_clk                        (core_clk),
      .rst_n                           (rst_n),
      .wr_force_event                  (wr_force_s[s]),
      .wr_socket_ctl                   (wr_sock_ctl_s[s]),
      .wr_system_ctl                   (wr_sys_ctl_s[s]),
      .wr_card_ctl                     (wr_card_ctl_s[s]),
      .wr_diagnostic                   (wr_diag_s[s]),
      .wdata                           (reg_wdata),
      .zoom_platform_supported_reg     (support_s[s]),
      .socket_zoom_enable_reg          (std_en_s[s]),
      .internal_clock_enable_reg       (clk_en_s[s]),
      .card_ctl_reg                    (card_ctl_s[s]),
      .standard_zoom_model_disable_reg (std_dis_s[s])
    );

    assign legacy_en_s[s] = card_ctl_s[s][SZVA_BIT_LEGACY_ZOOM_EN];
    assign spk_en_s[s]    = card_ctl_s[s][SZVA_BIT_SPEAKER_EN];
    assign pwm_route_s[s] = card_ctl_s[s][SZVA_BIT_PWM_ROUTE];

    // The standard enable is ignored while the standard model is disabled, but the
    // legacy enable always works so old drivers keep running.
    assign zoom_eff_s[s] = legacy_en_s[s] | (std_en_s[s] & ~std_dis_s[s]); // [RULE6] [RULE7] [RULE22]

    // One pin serves both card types; its meaning follows the detected card.
    assign card_speaker_in[s]  = battery_voltage_2_pin[s] & card_is_16bit[s] & card_io_mode[s]; // [RULE14]
    assign cardbus_audio_in[s] = battery_voltage_2_pin[s] & card_is_cardbus[s];
    assign audio_valid_s[s]    = spk_en_s[s] & (card_speaker_in[s] | cardbus_audio_in[s]);
  end

  assign zoom_in_use_any_socket = |zoom_eff_s; // [RULE3] [RULE21]

  // Read data are captured one cycle after the strobe; unmapped offsets read zero.
  always_comb begin
    rdata_next = SZVA_ZERO_WORD;
    if (!reg_cfg_space && reg_addr == SZVA_OFF_PRESENT_STATE) begin
      rdata_next[SZVA_BIT_PLATFORM_SUPPORT] = support_s[reg_func]; // [RULE1]
    end else if (!reg_cfg_space && reg_addr == SZVA_OFF_SOCKET_CTL) begin
      rdata_next[SZVA_BIT_ZOOM_ACTIVITY]  = zoom_in_use_any_socket; // [RULE3]
      rdata_next[SZVA_BIT_STD_MODEL]      = ~std_dis_s[reg_func]; // [RULE4] [RULE6]
      rdata_next[SZVA_BIT_SOCKET_ZOOM_EN] = std_en_s[reg_func]; // [RULE5]
    end else if (reg_cfg_space && reg_addr == SZVA_OFF_SYSTEM_CTL) begin
      rdata_next[SZVA_BIT_INTERNAL_CLK_EN] = clk_en_s[reg_func];
    end else if (reg_cfg_space && reg_addr == SZVA_OFF_CARD_CTL) begin
      rdata_next[7:0] = card_ctl_s[reg_func];
    end else if (reg_cfg_space && reg_addr == SZVA_OFF_DIAGNOSTIC) begin
      rdata_next[SZVA_BIT_STD_MODEL_DIS] = std_dis_s[reg_func];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata  <= SZVA_ZERO_WORD;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= reg_rd ? rdata_next : SZVA_ZERO_WORD;
      reg_rvalid <= reg_rd;
    end
  end

  // The ring oscillator itself is an analog macro; this enable gates it.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      internal_clock_enable <= 1'b0; // [RULE12]
    end else begin
      internal_clock_enable <= |clk_en_s; // [RULE11] [RULE12]
    end
  end

  // Pulls follow the card type so a floating status pin cannot raise a false event.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      status_change_pin_pullup_en   <= 2'b00;
      status_change_pin_pulldown_en <= 2'b00;
    end else begin
      status_change_pin_pullup_en   <= card_is_16bit; // [RULE13]
      status_change_pin_pulldown_en <= card_is_cardbus & ~card_is_16bit; // [RULE13]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      speaker_audio_out <= 1'b0;
    end else if (|spk_en_s) begin // [RULE16]
      speaker_audio_out <= audio_valid_s[0] ^ audio_valid_s[1]; // [RULE15]
    end else begin
      speaker_audio_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pwm_audio_out <= 1'b0;
    end else if (pwm_route_s[0]) begin // [RULE18]
      pwm_audio_out <= cardbus_audio_in[0]; // [RULE17]
    end else if (pwm_route_s[1]) begin
      pwm_audio_out <= cardbus_audio_in[1]; // [RULE17]
    end else begin
      pwm_audio_out <= 1'b0;
    end
  end

  // Only the legacy enable floats the upper address lines; the standard enable never does.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      addr_hi_release    <= 2'b00;
      socket_zoom_active <= 2'b00;
    end else begin
      addr_hi_release    <= legacy_en_s; // [RULE19]
      socket_zoom_active <= zoom_eff_s; // [RULE22]
    end
  end

  // Priority select lives in the socket 0 function; both functions share one mux.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      zoom_source_socket1 <= 1'b0;
    end else if (&zoom_eff_s) begin
      zoom_source_socket1 <= card_ctl_s[0][SZVA_BIT_PORT_SELECT]; // [RULE20]
    end else begin
      zoom_source_socket1 <= zoom_eff_s[1];
    end
  end

  a_force_sets_support: assert property ( // [RULE2]
    @(posedge core_clk) disable iff (!rst_n)
    (reg_wr && !reg_cfg_space && reg_addr == SZVA_OFF_FORCE_EVENT
      && reg_wdata[SZVA_BIT_PLATFORM_SUPPORT])
    |=> support_s[$past(reg_func)])
    else $error("Support flag not set by force event write.");

  a_support_read_back: assert property ( // [RULE1]
    @(posedge core_clk) disable iff (!rst_n)
    (reg_rd && !reg_cfg_space && reg_addr == SZVA_OFF_PRESENT_STATE)
    |=> reg_rvalid && reg_rdata[SZVA_BIT_PLATFORM_SUPPORT] == $past(support_s[reg_func]))
    else $error("Present state support bit wrong.");

  a_activity_read: assert property ( // [RULE3]
    @(posedge core_clk) disable iff (!rst_n)
    (reg_rd && !reg_cfg_space && reg_addr == SZVA_OFF_SOCKET_CTL)
    |=> reg_rdata[SZVA_BIT_ZOOM_ACTIVITY] == $past(|zoom_eff_s))
    else $error("Activity bit does not follow zoom enables.");

  a_std_model_bit: assert property ( // [RULE4]
    @(posedge core_clk) disable iff (!rst_n)
    (reg_rd && !reg_cfg_space && reg_addr == SZVA_OFF_SOCKET_CTL)
    |=> reg_rdata[SZVA_BIT_STD_MODEL] != $past(std_dis_s[reg_func]))
    else $error("Standard model bit disagrees with diagnostic.");

  a_legacy_zoom_on: assert property ( // [RULE7]
    @(posedge core_clk) disable iff (!rst_n)
    legacy_en_s[0] ##1 legacy_en_s[0] |-> socket_zoom_active[0] && addr_hi_release[0])
    else $error("Legacy zoom enable not honoured.");

  a_osc_enable: assert property ( // [RULE12]
    @(posedge core_clk) disable iff (!rst_n)
    (|clk_en_s) |=> internal_clock_enable)
    else $error("Oscillator enable missing.");

  a_pull_select: assert property ( // [RULE13]
    @(posedge core_clk) disable iff (!rst_n)
    card_is_16bit[1] |=> status_change_pin_pullup_en[1] && !status_change_pin_pulldown_en[1])
    else $error("Wrong pull on status change pin.");

  a_speaker_gate: assert property ( // [RULE16]
    @(posedge core_clk) disable iff (!rst_n)
    !(|spk_en_s) |=> !speaker_audio_out)
    else $error("Speaker output active while disabled.");

  a_speaker_xor: assert property ( // [RULE15]
    @(posedge core_clk) disable iff (!rst_n)
    (&spk_en_s && &card_is_cardbus)
    |=> speaker_audio_out == $past(battery_voltage_2_pin[0] ^ battery_voltage_2_pin[1]))
    else $error("Speaker output is not the XOR of both sockets.");

  a_pwm_priority: assert property ( // [RULE18]
    @(posedge core_clk) disable iff (!rst_n)
    (&pwm_route_s) |=> pwm_audio_out == $past(cardbus_audio_in[0]))
    else $error("Socket 0 PWM audio lost priority.");

  a_zoom_priority: assert property ( // [RULE20]
    @(posedge core_clk) disable iff (!rst_n)
    (&zoom_eff_s && !card_ctl_s[0][SZVA_BIT_PORT_SELECT]) |=> !zoom_source_socket1)
    else $error("Default zoom priority is not socket 0.");

  // The support flag is sticky, so firmware cannot lose it through a later write of 0.
  a_support_sticky: assert property ( // [RULE1]
    @(posedge core_clk) disable iff (!rst_n)
    support_s[0] |=> support_s[0])
    else $error("Support flag cleared without reset.");

  a_support_source: assert property ( // [RULE1] [RULE2]
    @(posedge core_clk) disable iff (!rst_n)
    $rose(support_s[0]) |-> $past(wr_force_s[0]))
    else $error("Support flag set without a force event write.");

  a_zoom_en_write: assert property ( // [RULE5]
    @(posedge core_clk) disable iff (!rst_n)
    wr_sock_ctl_s[1] |=> std_en_s[1] == $past(reg_wdata[SZVA_BIT_SOCKET_ZOOM_EN]))
    else $error("Socket zoom enable not stored.");

  a_std_dis_gate: assert property ( // [RULE6]
    @(posedge core_clk) disable iff (!rst_n)
    std_dis_s[1] && !legacy_en_s[1] |=> !socket_zoom_active[1])
    else $error("Standard enable honoured while model disabled.");

  a_effective_en: assert property ( // [RULE22]
    @(posedge core_clk) disable iff (!rst_n)
    (legacy_en_s[1] || (std_en_s[1] && !std_dis_s[1])) |=> socket_zoom_active[1])
    else $error("Effective zoom enable missing.");

  a_osc_off: assert property ( // [RULE12]
    @(posedge core_clk) disable iff (!rst_n)
    !(|clk_en_s) |=> !internal_clock_enable)
    else $error("Oscillator enabled without a request.");

  a_pulldown_cardbus: assert property ( // [RULE13]
    @(posedge core_clk) disable iff (!rst_n)
    card_is_cardbus[0] && !card_is_16bit[0]
    |=> status_change_pin_pulldown_en[0] && !status_change_pin_pullup_en[0])
    else $error("Wrong pull for a CardBus card.");

  a_pull_none: assert property ( // [RULE13]
    @(posedge core_clk) disable iff (!rst_n)
    !card_is_16bit[0] && !card_is_cardbus[0]
    |=> !status_change_pin_pullup_en[0] && !status_change_pin_pulldown_en[0])
    else $error("Pull enabled on an empty socket.");

  a_speaker_io_card: assert property ( // [RULE14]
    @(posedge core_clk) disable iff (!rst_n)
    spk_en_s[0] && !spk_en_s[1] && card_is_16bit[0] && card_io_mode[0]
    |=> speaker_audio_out == $past(battery_voltage_2_pin[0]))
    else $error("I/O card speaker input not passed through.");

  a_pwm_route_s1: assert property ( // [RULE17]
    @(posedge core_clk) disable iff (!rst_n)
    !pwm_route_s[0] && pwm_route_s[1] |=> pwm_audio_out == $past(cardbus_audio_in[1]))
    else $error("Socket 1 PWM audio not routed.");

  a_pwm_idle: assert property ( // [RULE17]
    @(posedge core_clk) disable iff (!rst_n)
    !(|pwm_route_s) |=> !pwm_audio_out)
    else $error("PWM audio active without routing.");

  a_addr_release: assert property ( // [RULE19]
    @(posedge core_clk) disable iff (!rst_n)
    legacy_en_s[1] |=> addr_hi_release[1])
    else $error("Upper address lines not released.");

  a_zoom_select: assert property ( // [RULE20]
    @(posedge core_clk) disable iff (!rst_n)
    &zoom_eff_s && card_ctl_s[0][SZVA_BIT_PORT_SELECT] |=> zoom_source_socket1)
    else $error("Priority select did not pick socket 1.");

endmodule : szva_ctl

// *** verilog/szva_pkg.sv ***
// Package of register offsets, bit positions and reset values for the socket zoom/audio block.
package szva_pkg;

  // Socket register space offsets (byte addresses).
  localparam logic [7:0] SZVA_OFF_PRESENT_STATE = 8'h08;
  localparam logic [7:0] SZVA_OFF_FORCE_EVENT   = 8'h0C;
  localparam logic [7:0] SZVA_OFF_SOCKET_CTL    = 8'h10;

  // Configuration space offsets (byte addresses).
  localparam logic [7:0] SZVA_OFF_SYSTEM_CTL    = 8'h80;
  localparam logic [7:0] SZVA_OFF_CARD_CTL      = 8'h91;
  localparam logic [7:0] SZVA_OFF_DIAGNOSTIC    = 8'h93;

  // Socket register bit positions.
  localparam int SZVA_BIT_PLATFORM_SUPPORT = 27;
  localparam int SZVA_BIT_ZOOM_ACTIVITY    = 11;
  localparam int SZVA_BIT_STD_MODEL        = 10;
  localparam int SZVA_BIT_SOCKET_ZOOM_EN   = 9;

  // Configuration register bit positions.
  localparam int SZVA_BIT_INTERNAL_CLK_EN  = 27;
  localparam int SZVA_BIT_SPEAKER_EN       = 1;
  localparam int SZVA_BIT_PWM_ROUTE        = 2;
  localparam int SZVA_BIT_PORT_SELECT      = 5;
  localparam int SZVA_BIT_LEGACY_ZOOM_EN   = 6;
  localparam int SZVA_BIT_STD_MODEL_DIS    = 0;

  // Implemented bits of the byte-wide card control register.
  localparam logic [7:0] SZVA_CARD_CTL_MASK = 8'h66;

  // Reset values.
  localparam logic [7:0]  SZVA_CARD_CTL_RST = 8'h00;
  localparam logic        SZVA_BIT_RST      = 1'b0;
  localparam logic [31:0] SZVA_ZERO_WORD    = 32'h0000_0000;
  localparam logic [7:0]  SZVA_ZERO_BYTE    = 8'h00;

  // Number of sockets.
  localparam int SZVA_SOCKETS = 2;

endpackage : szva_pkg

// *** verilog/szva_socket_regs.sv ***
// Per-socket register storage for zoom support, zoom enable, clock enable and card control.
`timescale 1ns/100ps
module szva_socket_regs
  import szva_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        wr_force_event,
  input  wire logic        wr_socket_ctl,
  input  wire logic        wr_system_ctl,
  input  wire logic        wr_card_ctl,
  input  wire logic        wr_diagnostic,
  input  wire logic [31:0] wdata,
  output logic             zoom_platform_supported_reg,
  output logic             socket_zoom_enable_reg,
  output logic             internal_clock_enable_reg,
  output logic [7:0]       card_ctl_reg,
  output logic             standard_zoom_model_disable_reg
);

  // The support flag has no write path of its own; only the force event write sets it.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      zoom_platform_supported_reg <= SZVA_BIT_RST;
    end else if (wr_force_event && wdata[SZVA_BIT_PLATFORM_SUPPORT]) begin // [RULE1] [RULE2]
      zoom_platform_supported_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      socket_zoom_enable_reg <= SZVA_BIT_RST;
    end else if (wr_socket_ctl) begin
      socket_zoom_enable_reg <= wdata[SZVA_BIT_SOCKET_ZOOM_EN]; // [RULE5]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      internal_clock_enable_reg <= SZVA_BIT_RST; // [RULE12]
    end else if (wr_system_ctl) begin
      internal_clock_enable_reg <= wdata[SZVA_BIT_INTERNAL_CLK_EN]; // [RULE12]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      card_ctl_reg <= SZVA_CARD_CTL_RST;
    end else if (wr_card_ctl) begin
      card_ctl_reg <= wdata[7:0] & SZVA_CARD_CTL_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      standard_zoom_model_disable_reg <= SZVA_BIT_RST;
    end else if (wr_diagnostic) begin
      standard_zoom_model_disable_reg <= wdata[SZVA_BIT_STD_MODEL_DIS]; // [RULE6]
    end
  end

endmodule : szva_socket_regs
